// ==== cfsr_top.sv ====
// charger fault and status register bank behind the host control port
//
// What this block does
// - the comparator pin conversion is 16-bit, zero at reset, 1 mV a step, saturated at 8191.
// - the fault status register sits at 20h, resets to 00h and holds eight flags, 1 meaning fault.
// - the six read-type faults set and latch their flag until at least one host read.
// - a read-type flag read while its fault is still present stays at 1 after the read.
// - once read, a read-type flag clears by itself as soon as its fault goes away.
// - a system overvoltage event sets bit 4, which the host may read and write.
// - while the system overvoltage or undervoltage flag is 1 the converter is held off.
// - writing 0 to bit 4 or removing the adapter clears it and lets the converter restart.
// - bit 3 latches system undervoltage until a 0 is written or the adapter is removed.
// - a low comparator output forces the converter off and sets bit 2 as a read-type flag.
// - the path status register at 21h resets to 00h and mirrors eight live status bits.
`timescale 1ns/10ps
`include "cfsr_consts.svh"

module cfsr_top #(
    parameter int RAW_W = 16
) (
    // clock, reset and enable
    input  wire logic               mclk,
    input  wire logic               sys_rst,
    input  wire logic               clkEn,

    // host register port and register-reset command
    input  wire logic [7:0]         regAddr,
    input  wire logic               regRdStb,
    input  wire logic               regWrStb,
    input  wire logic [7:0]         regWrData,
    output cfsr_pkg::cfsr_byte_t    regRdData,
    input  wire logic               regResetCmd,

    // fault detectors and adapter state
    input  wire logic               inOvDet,
    input  wire logic               batDischOcDet,
    input  wire logic               inOcDet,
    input  wire logic               sysOvEvent,
    input  wire logic               sysUvEvent,
    input  wire logic               cmpOut_n,
    input  wire logic               otgOvDet,
    input  wire logic               otgUvDet,
    input  wire logic               adapterRemoved,

    // live path status levels
    input  wire logic               inputSourcePresent,
    input  wire logic               currentOptimizerDone,
    input  wire logic               minVoltageProtActive,
    input  wire logic               inputVoltageRegActive,
    input  wire logic               inputCurrentRegActive,
    input  wire logic               busShortFault,
    input  wire logic               batChargeOcFault,
    input  wire logic               otgOutputActive,

    // conversion samples
    input  wire logic               adcValid,
    input  wire logic [RAW_W-1:0]   adcRaw,

    // converter control
    output logic                    converterOff
);

    localparam logic [7:0] READ_MASK = `CFSR_READ_TYPE_MASK;

    // decode and strobes
    cfsr_pkg::cfsr_sel_e  regSel;
    logic                 faultRead;
    logic                 faultWrite;

    // fault flags
    logic [7:0]           faultCond;
    logic [7:0]           latchFlag;
    cfsr_pkg::cfsr_byte_t faultByte;
    logic                 sysOvFlag_reg;
    logic                 sysOvFlag_next;
    logic                 sysUvFlag_reg;
    logic                 sysUvFlag_next;

    // converter control
    logic                 convOff_reg;
    logic                 convOff_next;

    // path status and conversion
    cfsr_pkg::cfsr_byte_t pathStat_reg;
    cfsr_pkg::cfsr_byte_t pathStat_next;
    cfsr_pkg::cfsr_byte_t pathLive;
    cfsr_pkg::cfsr_word_t convValue;
    cfsr_pkg::cfsr_byte_t convHiHold_reg;
    cfsr_pkg::cfsr_byte_t convHiHold_next;

    // read data
    cfsr_pkg::cfsr_byte_t rdData_reg;
    cfsr_pkg::cfsr_byte_t rdData_next;

    // address decode into a one-hot select
    always_comb begin
        if (regAddr == `CFSR_ADDR_CONV_LO) begin
            regSel = cfsr_pkg::SEL_CONV_LO;
        end else if (regAddr == `CFSR_ADDR_CONV_HI) begin
            regSel = cfsr_pkg::SEL_CONV_HI;
        end else if (regAddr == `CFSR_ADDR_FAULT) begin
            regSel = cfsr_pkg::SEL_FAULT;
        end else if (regAddr == `CFSR_ADDR_PATH) begin
            regSel = cfsr_pkg::SEL_PATH;
        end else begin
            regSel = cfsr_pkg::SEL_NONE;
        end
    end

    // host accesses that touch the fault register
    assign faultRead  = regRdStb && (regSel == cfsr_pkg::SEL_FAULT);
    assign faultWrite = regWrStb && (regSel == cfsr_pkg::SEL_FAULT);

    // live fault conditions for the read-type flags
    always_comb begin
        faultCond                    = 8'h00;
        faultCond[`CFSR_BIT_IN_OV]   = inOvDet;
        faultCond[`CFSR_BIT_BAT_DOC] = batDischOcDet;
        faultCond[`CFSR_BIT_IN_OC]   = inOcDet;
        faultCond[`CFSR_BIT_FRC_OFF] = ~cmpOut_n;
        faultCond[`CFSR_BIT_OTG_OV]  = otgOvDet;
        faultCond[`CFSR_BIT_OTG_UV]  = otgUvDet;
    end

    // one latch per read-type bit; the two write-clear bits live below
    generate
        for (genvar i = 0; i < 8; i++) begin : g_flag
            if (READ_MASK[i]) begin : g_latch
                cfsr_read_latch u_latch (
                    .mclk      (mclk),
                    .sys_rst   (sys_rst),
                    .clkEn     (clkEn),
                    .regClear  (regResetCmd),
                    .faultCond (faultCond[i]),
                    .hostRead  (faultRead),
                    .flag      (latchFlag[i])
                );
            end else begin : g_none
                assign latchFlag[i] = 1'b0;
            end
        end
    endgenerate

    // system overvoltage flag: event sets, write-0 or unplug clears
    always_comb begin
        sysOvFlag_next = sysOvFlag_reg;
        if (sysOvEvent) begin
            sysOvFlag_next = 1'b1;
        end else if (regResetCmd || adapterRemoved) begin
            sysOvFlag_next = 1'b0;
        end else if (faultWrite && !regWrData[`CFSR_BIT_SYS_OV]) begin
            sysOvFlag_next = 1'b0;
        end
    end

    // system undervoltage flag: event sets, write-0 or unplug clears
    always_comb begin
        sysUvFlag_next = sysUvFlag_reg;
        if (sysUvEvent) begin
            sysUvFlag_next = 1'b1;
        end else if (regResetCmd || adapterRemoved) begin
            sysUvFlag_next = 1'b0;
        end else if (faultWrite && !regWrData[`CFSR_BIT_SYS_UV]) begin
            sysUvFlag_next = 1'b0;
        end
    end

    // converter held off by either voltage flag or a low comparator
    always_comb begin
        convOff_next = sysOvFlag_next || sysUvFlag_next || !cmpOut_n;
    end

    // assembled fault register image
    always_comb begin
        faultByte                   = latchFlag;
        faultByte[`CFSR_BIT_SYS_OV] = sysOvFlag_reg;
        faultByte[`CFSR_BIT_SYS_UV] = sysUvFlag_reg;
    end

    // live path status inputs gathered into one byte
    always_comb begin
        pathLive                        = 8'h00;
        pathLive[`CFSR_BIT_SRC_PRESENT] = inputSourcePresent;
        pathLive[`CFSR_BIT_CURRENT_OPTIMIZER_DONE]    = currentOptimizerDone;
        pathLive[`CFSR_BIT_VAP_ACTIVE]  = minVoltageProtActive;
        pathLive[`CFSR_BIT_VIN_REG]     = inputVoltageRegActive;
        pathLive[`CFSR_BIT_IIN_REG]     = inputCurrentRegActive;
        pathLive[`CFSR_BIT_BUS_SHORT]   = busShortFault;
        pathLive[`CFSR_BIT_BAT_COC]     = batChargeOcFault;
        pathLive[`CFSR_BIT_OTG_ACTIVE]  = otgOutputActive;
    end

    // path status sampled every cycle, zeroed in every cycle the reset command is high
    always_comb begin
        if (regResetCmd) begin
            pathStat_next = `CFSR_PATH_RESET;
        end else begin
            pathStat_next = pathLive;
        end
    end

    // conversion result register with saturation
    cfsr_conv_clamp #(
        .RAW_W (RAW_W)
    ) u_conv (
        .mclk        (mclk),
        .sys_rst     (sys_rst),
        .clkEn       (clkEn),
        .regClear    (regResetCmd),
        .sampleValid (adcValid),
        .rawIn       (adcRaw),
        .result      (convValue)
    );

    // high byte frozen when the low byte is read, so the two reads pair up
    always_comb begin
        convHiHold_next = convHiHold_reg;
        if (regResetCmd) begin
            convHiHold_next = 8'h00;
        end else if (regRdStb && (regSel == cfsr_pkg::SEL_CONV_LO)) begin
            convHiHold_next = convValue[15:8];
        end
    end

    // read data mux, registered; unmapped addresses read zero
    always_comb begin
        rdData_next = rdData_reg;
        if (regRdStb) begin
            unique case (regSel)
                cfsr_pkg::SEL_CONV_LO: begin
                    rdData_next = convValue[7:0];
                end
                cfsr_pkg::SEL_CONV_HI: begin
                    rdData_next = convHiHold_reg;
                end
                cfsr_pkg::SEL_FAULT: begin
                    rdData_next = faultByte;
                end
                cfsr_pkg::SEL_PATH: begin
                    rdData_next = pathStat_reg;
                end
                cfsr_pkg::SEL_NONE: begin
                    rdData_next = `CFSR_UNMAPPED_DATA;
                end
            endcase
        end
    end

    // system overvoltage flag register, frozen while clkEn is low
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            sysOvFlag_reg <= 1'b0;
        end else if (clkEn) begin
            sysOvFlag_reg <= sysOvFlag_next;
        end
    end

    // system undervoltage flag register, frozen while clkEn is low
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            sysUvFlag_reg <= 1'b0;
        end else if (clkEn) begin
            sysUvFlag_reg <= sysUvFlag_next;
        end
    end

    // converter disable register, frozen while clkEn is low
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            convOff_reg <= 1'b0;
        end else if (clkEn) begin
            convOff_reg <= convOff_next;
        end
    end

    // path status register, frozen while clkEn is low
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            pathStat_reg <= `CFSR_PATH_RESET;
        end else if (clkEn) begin
            pathStat_reg <= pathStat_next;
        end
    end

    // high byte snapshot register, frozen while clkEn is low
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            convHiHold_reg <= 8'h00;
        end else if (clkEn) begin
            convHiHold_reg <= convHiHold_next;
        end
    end

    // read data register, frozen while clkEn is low
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            rdData_reg <= `CFSR_FAULT_RESET;
        end else if (clkEn) begin
            rdData_reg <= rdData_next;
        end
    end

    // outputs straight from flops
    assign regRdData    = rdData_reg;
    assign converterOff = convOff_reg;

endmodule : cfsr_top

// ==== cfsr_consts.svh ====
// register offsets, field positions, reset values and limits of the charger fault status bank
`ifndef CFSR_CONSTS_SVH
`define CFSR_CONSTS_SVH

// byte addresses on the host control port
`define CFSR_ADDR_CONV_LO    8'h1e
`define CFSR_ADDR_CONV_HI    8'h1f
`define CFSR_ADDR_FAULT      8'h20
`define CFSR_ADDR_PATH       8'h21

// reset values
`define CFSR_FAULT_RESET     8'h00
`define CFSR_PATH_RESET      8'h00
`define CFSR_CONV_RESET      16'h0000
`define CFSR_UNMAPPED_DATA   8'h00

// conversion result: 1 mV per step, saturates at 8191 mV
`define CFSR_CONV_MAX        16'h1fff

// fault status bit positions
`define CFSR_BIT_IN_OV       7
`define CFSR_BIT_BAT_DOC     6
`define CFSR_BIT_IN_OC       5
`define CFSR_BIT_SYS_OV      4
`define CFSR_BIT_SYS_UV      3
`define CFSR_BIT_FRC_OFF     2
`define CFSR_BIT_OTG_OV      1
`define CFSR_BIT_OTG_UV      0

// bits that clear through the read-then-release sequence
`define CFSR_READ_TYPE_MASK  8'he7

// power path status bit positions
`define CFSR_BIT_SRC_PRESENT 7
`define CFSR_BIT_CURRENT_OPTIMIZER_DONE    6
`define CFSR_BIT_VAP_ACTIVE  5
`define CFSR_BIT_VIN_REG     4
`define CFSR_BIT_IIN_REG     3
`define CFSR_BIT_BUS_SHORT   2
`define CFSR_BIT_BAT_COC     1
`define CFSR_BIT_OTG_ACTIVE  0

`endif

// ==== cfsr_pkg.sv ====
// types shared by the charger fault status bank
package cfsr_pkg;

    typedef logic [7:0]  cfsr_byte_t;
    typedef logic [15:0] cfsr_word_t;

    // decoded register select, one-hot
    typedef enum logic [4:0] {
        SEL_NONE    = 5'b00001,
        SEL_CONV_LO = 5'b00010,
        SEL_CONV_HI = 5'b00100,
        SEL_FAULT   = 5'b01000,
        SEL_PATH    = 5'b10000
    } cfsr_sel_e;

endpackage : cfsr_pkg

// ==== cfsr_read_latch.sv ====
// one fault flag that latches until read and self-clears once read and released
`timescale 1ns/10ps

module cfsr_read_latch (
    input  wire logic mclk,
    input  wire logic sys_rst,
    input  wire logic clkEn,
    input  wire logic regClear,
    input  wire logic faultCond,
    input  wire logic hostRead,
    output logic      flag
);

    logic flag_reg;
    logic flag_next;
    logic readSeen_reg;
    logic readSeen_next;

    // set wins over read and register-reset clears
    always_comb begin
        flag_next     = flag_reg;
        readSeen_next = readSeen_reg;
        if (faultCond) begin
            flag_next = 1'b1;
        end else if (regClear) begin
            flag_next = 1'b0;
        end else if (flag_reg && (hostRead || readSeen_reg)) begin
            flag_next = 1'b0;
        end
        // remember a read that happened while the flag stood
        if (!flag_next || regClear) begin
            readSeen_next = 1'b0;
        end else if (hostRead && flag_reg) begin
            readSeen_next = 1'b1;
        end
    end

    // state registers, frozen while clkEn is low
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            flag_reg     <= 1'b0;
            readSeen_reg <= 1'b0;
        end else if (clkEn) begin
            flag_reg     <= flag_next;
            readSeen_reg <= readSeen_next;
        end
    end

    assign flag = flag_reg;

endmodule : cfsr_read_latch

// ==== cfsr_conv_clamp.sv ====
// comparator pin conversion result register with upper saturation
`timescale 1ns/10ps
`include "cfsr_consts.svh"

module cfsr_conv_clamp #(
    parameter int RAW_W = 16
) (
    input  wire logic                mclk,
    input  wire logic                sys_rst,
    input  wire logic                clkEn,
    input  wire logic                regClear,
    input  wire logic                sampleValid,
    input  wire logic [RAW_W-1:0]    rawIn,
    output cfsr_pkg::cfsr_word_t     result
);

    localparam logic [RAW_W-1:0] RAW_MAX = RAW_W'(`CFSR_CONV_MAX);

    cfsr_pkg::cfsr_word_t result_reg;
    cfsr_pkg::cfsr_word_t result_next;

    // saturate a new sample, or zero on register reset
    always_comb begin
        result_next = result_reg;
        if (regClear) begin
            result_next = `CFSR_CONV_RESET;
        end else if (sampleValid) begin
            if (rawIn > RAW_MAX) begin
                result_next = `CFSR_CONV_MAX;
            end else begin
                result_next = 16'(rawIn);
            end
        end
    end

    // result register, zero after reset
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            result_reg <= `CFSR_CONV_RESET;
        end else if (clkEn) begin
            result_reg <= result_next;
        end
    end

    assign result = result_reg;

endmodule : cfsr_conv_clamp

// ==== cfsr_sva.sv ====
// concurrent checks on the charger fault status bank ports
`timescale 1ns/10ps
`include "cfsr_consts.svh"

module cfsr_sva #(
    parameter int RAW_W = 16
) (
    input wire logic                 mclk,
    input wire logic                 sys_rst,
    input wire logic                 clkEn,
    input wire logic [7:0]           regAddr,
    input wire logic                 regRdStb,
    input wire cfsr_pkg::cfsr_byte_t regRdData,
    input wire logic                 regResetCmd,
    input wire logic                 inOvDet,
    input wire logic                 sysOvEvent,
    input wire logic                 sysUvEvent,
    input wire logic                 cmpOut_n,
    input wire logic                 adapterRemoved,
    input wire logic                 inputSourcePresent,
    input wire logic                 currentOptimizerDone,
    input wire logic                 minVoltageProtActive,
    input wire logic                 inputVoltageRegActive,
    input wire logic                 inputCurrentRegActive,
    input wire logic                 busShortFault,
    input wire logic                 batChargeOcFault,
    input wire logic                 otgOutputActive,
    input wire logic                 converterOff
);
    logic [7:0] pathVec;
    logic       rdFault;
    logic       rdPath;
    logic       noCause;

    // live status in register order, decoded reads
    assign pathVec = {inputSourcePresent, currentOptimizerDone, minVoltageProtActive,
                      inputVoltageRegActive, inputCurrentRegActive, busShortFault,
                      batChargeOcFault, otgOutputActive};
    assign rdFault = clkEn && regRdStb && (regAddr == `CFSR_ADDR_FAULT);
    assign rdPath  = clkEn && regRdStb && (regAddr == `CFSR_ADDR_PATH);
    assign noCause = clkEn && cmpOut_n && !sysOvEvent && !sysUvEvent;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);

    // read while the fault has stood a cycle, then the fault goes away before a second read
    sequence readHigh_s;
        rdFault && inOvDet && $past(inOvDet) && $past(clkEn) && !regResetCmd
        ##1 clkEn && inOvDet && !regResetCmd;
    endsequence
    sequence readGone_s;
        clkEn && !inOvDet && !regResetCmd ##1 rdFault && !inOvDet;
    endsequence

    cmp_forces_off_a: assert property (clkEn && !cmpOut_n |=> converterOff)
        else $error("converter not off after low comparator");
    sys_event_off_a: assert property (clkEn && (sysOvEvent || sysUvEvent) |=> converterOff)
        else $error("converter not off after system event");
    unmapped_read_a: assert property (
        clkEn && regRdStb && (regAddr > `CFSR_ADDR_PATH || regAddr < `CFSR_ADDR_CONV_LO)
        |=> regRdData == `CFSR_UNMAPPED_DATA)
        else $error("unmapped read not zero");
    read_data_hold_a: assert property (!(clkEn && regRdStb) |=> $stable(regRdData))
        else $error("read data moved without a read");
    path_mirror_a: assert property (
        rdPath && $past(clkEn) && !$past(regResetCmd) && !$past(sys_rst)
        |=> regRdData == $past(pathVec, 2))
        else $error("path status does not mirror inputs");
    fault_kept_a: assert property (
        rdFault && inOvDet && $past(inOvDet) && $past(clkEn) && !$past(sys_rst)
        |=> regRdData[`CFSR_BIT_IN_OV])
        else $error("present fault read as clear");
    self_clear_a: assert property (readHigh_s ##1 readGone_s |=> !regRdData[`CFSR_BIT_IN_OV])
        else $error("read fault did not clear by itself");
    unplug_release_a: assert property (
        noCause && adapterRemoved && !regResetCmd |=> !converterOff)
        else $error("converter still off after unplug");
    reset_cmd_clear_a: assert property (noCause && regResetCmd |=> !converterOff)
        else $error("converter still off after register reset");
endmodule : cfsr_sva

bind cfsr_top cfsr_sva #(.RAW_W(RAW_W)) u_sva (.mclk, .sys_rst, .clkEn, .regAddr, .regRdStb,
    .regRdData, .regResetCmd, .inOvDet, .sysOvEvent, .sysUvEvent, .cmpOut_n, .adapterRemoved,
    .inputSourcePresent, .currentOptimizerDone, .minVoltageProtActive, .inputVoltageRegActive,
    .inputCurrentRegActive, .busShortFault, .batChargeOcFault, .otgOutputActive, .converterOff);

// ==== cfsr_host.sv ====
// host side model of the register port
`timescale 1ns/10ps

module cfsr_host (
    input  wire logic       mclk,
    output logic [7:0]      regAddr,
    output logic            regRdStb,
    output logic            regWrStb,
    output logic [7:0]      regWrData,
    input  wire logic [7:0] regRdData
);
    // idle bus at time zero
    initial begin
        regAddr   = 8'h00;
        regRdStb  = 1'b0;
        regWrStb  = 1'b0;
        regWrData = 8'h00;
    end

    // one read strobe, data taken once the answering edge has landed
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge mclk);
        regAddr  <= a;
        regRdStb <= 1'b1;
        @(posedge mclk);
        regRdStb <= 1'b0;
        regAddr  <= ~a; // released lines do not keep the old value
        #1 d = regRdData;
    endtask : rd

    // one write strobe, clearing a latched flag takes a written 0
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge mclk);
        regAddr   <= a;
        regWrData <= v;
        regWrStb  <= 1'b1;
        @(posedge mclk);
        regWrStb  <= 1'b0;
        regAddr   <= ~a;
        regWrData <= ~v;
        #1;
    endtask : wr
endmodule : cfsr_host

// ==== charger_fault_status_regs_tb.sv ====
// self-checking bench for the charger fault status bank
`timescale 1ns/10ps

module charger_fault_status_regs_tb;
    logic                 mclk           = 1'b0;
    logic                 sys_rst        = 1'b1;
    logic                 clkEn          = 1'b1;
    logic                 regResetCmd    = 1'b0;
    logic                 adapterRemoved = 1'b0;
    logic                 adcValid       = 1'b0;
    logic [15:0]          adcRaw         = 16'h0000;
    logic [7:0]           fv             = 8'h00;
    logic [7:0]           pathVec        = 8'h00;
    logic [7:0]           regAddr;
    logic [7:0]           regWrData;
    logic                 regRdStb;
    logic                 regWrStb;
    logic                 converterOff;
    cfsr_pkg::cfsr_byte_t regRdData;
    logic [15:0]          expConv;
    logic [15:0]          raws [4] = '{16'h1234, 16'h1fff, 16'h2000, 16'hffff};
    int                   numErrors  = 0;
    int                   checkCount = 0;

    // clock
    always #10 mclk = ~mclk;

    // device and host
    cfsr_top #(.RAW_W(16)) dut (.mclk, .sys_rst, .clkEn, .regAddr, .regRdStb, .regWrStb,
        .regWrData, .regRdData, .regResetCmd, .inOvDet(fv[7]), .batDischOcDet(fv[6]),
        .inOcDet(fv[5]), .sysOvEvent(fv[4]), .sysUvEvent(fv[3]), .cmpOut_n(~fv[2]),
        .otgOvDet(fv[1]), .otgUvDet(fv[0]), .adapterRemoved, .inputSourcePresent(pathVec[7]),
        .currentOptimizerDone(pathVec[6]), .minVoltageProtActive(pathVec[5]),
        .inputVoltageRegActive(pathVec[4]), .inputCurrentRegActive(pathVec[3]),
        .busShortFault(pathVec[2]), .batChargeOcFault(pathVec[1]),
        .otgOutputActive(pathVec[0]), .adcValid, .adcRaw, .converterOff);
    cfsr_host host (.mclk, .regAddr, .regRdStb, .regWrStb, .regWrData, .regRdData);

    // comparison and verdict helpers
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checkCount++;
        if (seen !== exp) begin
            numErrors++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic rc(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        host.rd(a, d);
        chk(d, exp);
    endtask : rc
    task automatic pulse(input int i);
        @(posedge mclk);
        fv[i] <= 1'b1;
        @(posedge mclk);
        fv[i] <= 1'b0;
        #1;
    endtask : pulse
    task automatic stopTest;
        $display("errors %0d checks %0d", numErrors, checkCount);
        if (numErrors == 0 && checkCount > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : stopTest

    // watchdog well past the expected run
    initial begin
        #200us;
        numErrors++;
        stopTest();
    end

    // main sequence
    initial begin
        repeat (6) @(posedge mclk);
        sys_rst <= 1'b0;
        for (int a = 8'h1e; a <= 8'h22; a++) rc(8'(a), 8'h00);
        for (int i = 0; i < 4; i++) begin
            @(posedge mclk);
            adcRaw   <= raws[i];
            adcValid <= 1'b1;
            @(posedge mclk);
            adcValid <= 1'b0;
            adcRaw   <= ~raws[i];
            expConv = (raws[i] > 16'h1fff) ? 16'h1fff : raws[i];
            rc(8'h1e, expConv[7:0]);
            rc(8'h1f, expConv[15:8]);
        end
        for (int i = 0; i < 8; i++) begin
            if (i == 3 || i == 4) continue;
            pulse(i);
            if (i == 2) chk({7'h00, converterOff}, 8'h01);
            rc(8'h20, 8'h01 << i);
            rc(8'h20, 8'h00);
        end
        @(posedge mclk);
        clkEn <= 1'b0;
        pulse(7);
        @(posedge mclk);
        clkEn <= 1'b1;
        rc(8'h20, 8'h00);
        @(posedge mclk);
        fv[7] <= 1'b1;
        rc(8'h20, 8'h80);
        rc(8'h20, 8'h80);
        @(posedge mclk);
        fv[7] <= 1'b0;
        rc(8'h20, 8'h00);
        pulse(4);
        chk({7'h00, converterOff}, 8'h01);
        rc(8'h20, 8'h10);
        host.wr(8'h20, 8'hff);
        rc(8'h20, 8'h10);
        host.wr(8'h20, 8'h00);
        chk({7'h00, converterOff}, 8'h00);
        rc(8'h20, 8'h00);
        pulse(3);
        pulse(4);
        rc(8'h20, 8'h18);
        host.wr(8'h20, 8'h10);
        rc(8'h20, 8'h10);
        chk({7'h00, converterOff}, 8'h01);
        @(posedge mclk);
        adapterRemoved <= 1'b1;
        @(posedge mclk);
        adapterRemoved <= 1'b0;
        rc(8'h20, 8'h00);
        chk({7'h00, converterOff}, 8'h00);
        @(posedge mclk);
        pathVec <= 8'ha5;
        rc(8'h21, 8'ha5);
        @(posedge mclk);
        pathVec <= 8'h5a;
        rc(8'h21, 8'h5a);
        pulse(4);
        pulse(6);
        @(posedge mclk);
        regResetCmd <= 1'b1;
        rc(8'h21, 8'h00);
        @(posedge mclk);
        regResetCmd <= 1'b0;
        rc(8'h20, 8'h00);
        rc(8'h1e, 8'h00);
        rc(8'h1f, 8'h00);
        chk({7'h00, converterOff}, 8'h00);
        stopTest();
    end
endmodule : charger_fault_status_regs_tb
